/* gpio_port.sv */
// One general-purpose digital I/O port with APB register access
//
// Behaviour
// - Direction bit one makes output, zero input
// - Input, value one, no disable: pull-up on
// - Value zero or output: pull-up off
// - Reset tri-states every pin without clock
// - Output pin drives the value bit level
// - Global disable keeps all pull-ups off
// - Pin state readable whatever the direction
// - Falling-edge latch then rising-edge state bit
// - Pad change seen within half to 1.5 periods
// - Own written value visible one period later
// - Sleep clamps digital input to ground
// - Enabled external interrupt bypasses sleep clamp
// - Clamp release edge raises any-change event
// - Clock and clamp shared; disable and strobes per port
// - Pin state read only, others read/write
// - Pull-up disable is control bit 2, reset 0
//
// The register addresses and the APB register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module gpio_port #(
	parameter int PINS = gpio_port_pkg::PORT_PINS         // pins in this port
) (
	input  wire logic                              CORE_CLK,
	input  wire logic                              RESET,
	input  wire logic                              PSEL,
	input  wire logic                              PENABLE,
	input  wire logic                              PWRITE,
	input  wire logic [gpio_port_pkg::ADDR_W-1:0]  PADDR,
	input  wire logic [gpio_port_pkg::DATA_W-1:0]  PWDATA,
	output var  logic                              PREADY,
	output var  logic [gpio_port_pkg::DATA_W-1:0]  PRDATA,
	output var  logic                              PSLVERR,
	input  wire logic [PINS-1:0]                   PAD_IN,
	output var  logic [PINS-1:0]                   PAD_OUT,
	output var  logic [PINS-1:0]                   PAD_OE,
	output var  logic [PINS-1:0]                   PULLUP_EN,
	input  wire logic                              SLEEP_CLAMP,
	input  wire logic [PINS-1:0]                   EXT_INT_EN,
	output var  logic [PINS-1:0]                   INPUT_CHANGE
);
	import gpio_port_pkg::*;

	// ==========================================================
	// Parameter check
	generate
		if (PINS < 1 || PINS > DATA_W) begin : g_bad_pins
			$error("PINS must lie between 1 and 32");
		end
	endgenerate

	// ==========================================================
	// Bus request decode
	apb_req_t        req;                   // bundled request
	logic            pready_q;              // access answered this cycle
	logic            access;                // access phase in progress
	logic            commit;                // edge at which the transfer completes
	logic            hit_dir;               // direction_register selected
	logic            hit_out;               // output_value_register selected
	logic            hit_state;             // pin_state_register selected
	logic            hit_spec;              // special_function_control selected
	logic            mapped;                // any known offset
	logic            direction_write_strobe;    // shared by all pins of the port
	logic            output_value_write_strobe; // shared by all pins of the port
	logic            special_write_strobe;      // control register write

	assign req       = '{sel: PSEL, en: PENABLE, wr: PWRITE, addr: PADDR, wdata: PWDATA};
	assign access    = req.sel & req.en;
	assign commit    = access & pready_q;
	assign hit_dir   = (req.addr == OFS_DIRECTION);
	assign hit_out   = (req.addr == OFS_OUTPUT);
	assign hit_state = (req.addr == OFS_PIN_STATE);
	assign hit_spec  = (req.addr == OFS_SPECIAL);
	assign mapped    = hit_dir | hit_out | hit_state | hit_spec;

	// One strobe per register drives every pin bit at once
	assign direction_write_strobe    = commit & req.wr & hit_dir;
	assign output_value_write_strobe = commit & req.wr & hit_out;
	assign special_write_strobe      = commit & req.wr & hit_spec;

	// ==========================================================
	// Configuration registers
	logic [PINS-1:0] dir_q;                  // pin_direction_bit per pin
	logic [PINS-1:0] dir_d;
	logic [PINS-1:0] out_q;                  // pin_output_value_bit per pin
	logic [PINS-1:0] out_d;
	logic            pud_q;                  // global_pullup_disable
	logic            pud_d;

	// Next values; the pin-state location takes no write at all
	always_comb begin
		dir_d = dir_q;
		out_d = out_q;
		pud_d = pud_q;
		if (direction_write_strobe) begin
			dir_d = req.wdata[PINS-1:0];
		end
		if (output_value_write_strobe) begin
			out_d = req.wdata[PINS-1:0];
		end
		if (special_write_strobe) begin
			pud_d = req.wdata[PUD_BIT];
		end
	end

	// Direction: every pin starts as an input
	always_ff @(posedge CORE_CLK) begin
		if (RESET) begin
			dir_q <= DIR_RESET[PINS-1:0];
		end else begin
			dir_q <= dir_d;
		end
	end

	// Output value: starts at zero, so no pull-up at reset
	always_ff @(posedge CORE_CLK) begin
		if (RESET) begin
			out_q <= OUT_RESET[PINS-1:0];
		end else begin
			out_q <= out_d;
		end
	end

	// Global pull-up disable, one bit held in this port for all of its pins
	always_ff @(posedge CORE_CLK) begin
		if (RESET) begin
			pud_q <= PUD_RESET;
		end else begin
			pud_q <= pud_d;
		end
	end

	// ==========================================================
	// Pad drive
	logic [PINS-1:0] pull_q;                 // registered pull-up enable

	// Pull-up from next values so it moves in step with the pad drive
	always_ff @(posedge CORE_CLK) begin
		if (RESET) begin
			pull_q <= '0;
		end else begin
			pull_q <= ~dir_d & out_d & {PINS{~pud_d}};
		end
	end

	// Trade-off: these two outputs pass one gate after their flops; that is the
	// price of tri-stating the pads even while CORE_CLK is stopped
	// Reset gates the enables directly: tri-state must not wait for a clock edge
	assign PAD_OE    = dir_q & {PINS{~RESET}};
	assign PULLUP_EN = pull_q & {PINS{~RESET}};
	assign PAD_OUT   = out_q;

	// ==========================================================
	// Input path and synchroniser
	logic [PINS-1:0] clamp;                  // clamp active per pin
	logic [PINS-1:0] din;                    // digital input after the clamp
	logic [PINS-1:0] sync_q;                 // falling-edge stage, the latch
	logic [PINS-1:0] state_q;                // pin_state_bit per pin
	logic [PINS-1:0] prev_q;                 // previous pin state
	logic [PINS-1:0] change_q;               // one-cycle change event
	logic            state_ok_q;             // pin state holds a real pad sample
	logic            prev_ok_q;              // previous pin state holds one too

	// Sleep clamp is shared; an enabled external interrupt keeps its pin live
	assign clamp = {PINS{SLEEP_CLAMP}} & ~EXT_INT_EN;
	assign din   = PAD_IN & ~clamp;

	// Half a period lets the first stage settle; only the second stage reads it
	// First stage holds on the falling edge, like a latch open while high
	always_ff @(negedge CORE_CLK) begin
		if (RESET) begin
			sync_q <= '0;
		end else begin
			sync_q <= din;
		end
	end

	// Second stage on the rising edge; read back for any direction
	always_ff @(posedge CORE_CLK) begin
		if (RESET) begin
			state_q <= '0;
		end else begin
			state_q <= sync_q;
		end
	end

	// Arming: the first sample after reset would be compared with the reset
	// value and report a change that never happened on the pad
	always_ff @(posedge CORE_CLK) begin
		if (RESET) begin
			state_ok_q <= 1'b0;
			prev_ok_q  <= 1'b0;
		end else begin
			state_ok_q <= 1'b1;
			prev_ok_q  <= state_ok_q;
		end
	end

	// Any-change detector; releasing the clamp on a high pin gives an edge
	always_ff @(posedge CORE_CLK) begin
		if (RESET) begin
			prev_q   <= '0;
			change_q <= '0;
		end else begin
			prev_q   <= state_q;
			change_q <= (state_q ^ prev_q) & {PINS{prev_ok_q}};
		end
	end

	assign INPUT_CHANGE = change_q;

	// ==========================================================
	// APB answer
	logic [DATA_W-1:0] rdata_q;              // read data register
	logic [DATA_W-1:0] rdata_d;
	logic              err_q;                // unmapped access flag

	// Read mux; unused upper bits read as zero
	always_comb begin
		rdata_d = '0;
		if (hit_dir) begin
			rdata_d[PINS-1:0] = dir_q;
		end else if (hit_out) begin
			rdata_d[PINS-1:0] = out_q;
		end else if (hit_state) begin
			rdata_d[PINS-1:0] = state_q;
		end else if (hit_spec) begin
			rdata_d[PUD_BIT] = pud_q;
		end
	end

	// Ready rises one cycle into the access phase, data and error with it
	always_ff @(posedge CORE_CLK) begin
		if (RESET) begin
			pready_q <= 1'b0;
			rdata_q  <= '0;
			err_q    <= 1'b0;
		end else if (access & ~pready_q) begin
			pready_q <= 1'b1;
			rdata_q  <= req.wr ? '0 : rdata_d;
			err_q    <= ~mapped;
		end else begin
			pready_q <= 1'b0;
			err_q    <= 1'b0;
		end
	end

	assign PREADY  = pready_q;
	assign PRDATA  = rdata_q;
	assign PSLVERR = err_q;

	// ==========================================================
	// Assertions
	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (RESET);

	a_dir_write_drive: assert property (
		direction_write_strobe |=> PAD_OE == $past(req.wdata[PINS-1:0]))
		else $error("direction write did not reach output enable");

	a_pull_select: assert property (
		PULLUP_EN == (~PAD_OE & PAD_OUT & {PINS{~pud_q}}))
		else $error("pull-up does not match direction, value and disable");

	a_pull_off_out: assert property (
		(PULLUP_EN & (PAD_OE | ~PAD_OUT)) == '0)
		else $error("pull-up left on for an output pin");

	a_reset_tristate: assert property (@(posedge CORE_CLK) disable iff (1'b0)
		RESET |-> (PAD_OE == '0 && PULLUP_EN == '0))
		else $error("pins not tri-stated during reset");

	a_out_level: assert property (
		output_value_write_strobe |=> PAD_OUT == $past(req.wdata[PINS-1:0]))
		else $error("output value write not driven");

	a_pud_all_off: assert property (
		pud_q |-> PULLUP_EN == '0)
		else $error("pull-up on while globally disabled");

	a_sync_level: assert property (
		!$past(RESET) && (din == $past(din)) && ($past(din) == $past(din, 2))
			|-> state_q == din)
		else $error("stable pad not seen in pin state");

	a_sleep_clamp: assert property (
		(SLEEP_CLAMP && EXT_INT_EN[0] == 1'b0)[*3] |-> state_q[0] == 1'b0)
		else $error("clamped pin shows a high state");

	a_state_readonly: assert property (
		commit && req.wr && hit_state |=> $stable(dir_q) && $stable(out_q))
		else $error("write to pin state changed configuration");

	a_pud_write: assert property (
		special_write_strobe |=> pud_q == $past(req.wdata[PUD_BIT]))
		else $error("pull-up disable bit not written");

	a_change_event: assert property (
		$changed(state_q) && !$past(RESET, 2)
			|=> INPUT_CHANGE == ($past(state_q) ^ $past(state_q, 2)))
		else $error("pin change event missing");

	a_apb_answer: assert property (
		access && !pready_q |=> pready_q ##1 !pready_q)
		else $error("APB answer not given in one cycle");

	// Pad-facing checks rely on PAD_IN settling between rising edges
	// and on the clamp being the only thing between pad and first stage
	a_pad_latency: assert property (
		$changed(din) |=> state_q == $past(din))
		else $error("pad change not in pin state after one period");

	a_no_reset_event: assert property (
		$past(RESET, 3) |-> INPUT_CHANGE == '0)
		else $error("change event reported straight after reset");

	a_clamp_bypass: assert property (
		(SLEEP_CLAMP && $stable(EXT_INT_EN) && $stable(PAD_IN & EXT_INT_EN))[*3]
			|-> (state_q & EXT_INT_EN) == (PAD_IN & EXT_INT_EN))
		else $error("interrupt pin clamped during sleep");

	a_pin_state_read: assert property (
		commit && !req.wr && hit_state |-> PRDATA[PINS-1:0] == $past(state_q))
		else $error("pin state read returned wrong data");

	a_state_write_ok: assert property (
		commit && req.wr && hit_state |-> !PSLVERR)
		else $error("write to pin state flagged as error");

	a_reset_values: assert property (
		$past(RESET) |-> dir_q == '0 && out_q == '0 && !pud_q)
		else $error("configuration not zero after reset");

	a_err_unmapped: assert property (
		access && !pready_q && !mapped |=> PSLVERR && PRDATA == '0)
		else $error("unmapped access not flagged");

	a_write_unmapped: assert property (
		commit && req.wr && !mapped |=> $stable(dir_q) && $stable(out_q) && $stable(pud_q))
		else $error("unmapped write changed configuration");

endmodule
`default_nettype wire

/* gpio_port_pkg.sv */
// Constants and types shared by the general-purpose port block
`default_nettype none
package gpio_port_pkg;

	// ==========================================================
	// Bus geometry
	localparam int ADDR_W = 12;                    // APB address width
	localparam int DATA_W = 32;                    // APB data width

	// ==========================================================
	// Register byte offsets
	localparam logic [ADDR_W-1:0] OFS_DIRECTION = 12'h000; // direction_register
	localparam logic [ADDR_W-1:0] OFS_OUTPUT    = 12'h004; // output_value_register
	localparam logic [ADDR_W-1:0] OFS_PIN_STATE = 12'h008; // pin_state_register
	localparam logic [ADDR_W-1:0] OFS_SPECIAL   = 12'h00c; // special_function_control

	// ==========================================================
	// Field positions and reset values
	localparam int                PUD_BIT       = 2;     // global_pullup_disable position
	localparam logic              PUD_RESET     = 1'b0;  // pull-ups allowed after reset
	localparam int                PORT_PINS     = 8;     // default pins per port
	localparam logic [DATA_W-1:0] DIR_RESET     = 32'h0; // all pins input
	localparam logic [DATA_W-1:0] OUT_RESET     = 32'h0; // no pull-ups, drive low

	// ==========================================================
	// Timing
	localparam int CLK_PERIOD_NS = 25;             // CORE_CLK at 40 MHz
	localparam int READBACK_NS   = 25;             // write to pin-state visibility
	localparam int READBACK_CYC  = (READBACK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// ==========================================================
	// Carrier for one APB request as seen by the slave
	typedef struct packed {
		logic              sel;                    // psel
		logic              en;                     // penable
		logic              wr;                     // pwrite
		logic [ADDR_W-1:0] addr;                   // paddr
		logic [DATA_W-1:0] wdata;                  // pwdata
	} apb_req_t;

endpackage
`default_nettype wire

/* ext_pad.sv */
// Behavioural model of the circuitry attached to the port pads
`timescale 1ns/1ps
`default_nettype none
module ext_pad #(
	parameter int PINS = 8                  // pins in the port
) (
	input  wire logic            clk,       // core clock, paces the float pattern
	input  wire logic [PINS-1:0] pad_out,   // device drive level
	input  wire logic [PINS-1:0] pad_oe,    // device drives the pad
	input  wire logic [PINS-1:0] pullup_en, // device pull-up on
	input  wire logic [PINS-1:0] drive_en,  // external source drives the pad
	input  wire logic [PINS-1:0] drive_val, // external source level
	output var  logic [PINS-1:0] pad_in     // resolved pad level
);
	// ==========================================================
	// Floating level
	// A released pad flips every cycle so a stale value never passes as a match
	logic [PINS-1:0] float_q = '0;          // pattern shown on undriven pads
	always_ff @(posedge clk) begin
		float_q <= ~float_q;
	end

	// ==========================================================
	// Pad resolution: device drive, then external drive, then pull-up
	always_comb begin
		for (int i = 0; i < PINS; i++) begin
			if (pad_oe[i]) begin
				pad_in[i] = pad_out[i];
			end else if (drive_en[i]) begin
				pad_in[i] = drive_val[i];       // Strong external source wins
			end else if (pullup_en[i]) begin
				pad_in[i] = 1'b1;
			end else begin
				pad_in[i] = float_q[i];
			end
		end
	end
endmodule
`default_nettype wire

/* gpio_port_bench.sv */
// Self-checking bench for the general-purpose port over APB
`timescale 1ns/1ps
`default_nettype none
module gpio_port_bench;
	import gpio_port_pkg::*;
	// ==========================================================
	// Signals
	logic              clk, rst;             // clock and reset
	logic              psel, penable, pwrite; // APB request
	logic [ADDR_W-1:0] paddr;                // APB address
	logic [DATA_W-1:0] pwdata, prdata;       // APB data
	logic              pready, pslverr;      // APB answer
	logic [7:0]        pad_in, pad_out, pad_oe, pullup_en, change;
	logic [7:0]        drv_en, drv_val, int_en; // far-side stimulus
	logic              clamp;                // sleep clamp
	logic [DATA_W-1:0] rd;                   // last read data
	logic              er;                   // last error flag
	int                err_total, n_tests;

	gpio_port #(.PINS(8)) gpio_port_inst (.CORE_CLK(clk), .RESET(rst), .PSEL(psel),
		.PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
		.PREADY(pready), .PRDATA(prdata), .PSLVERR(pslverr), .PAD_IN(pad_in),
		.PAD_OUT(pad_out), .PAD_OE(pad_oe), .PULLUP_EN(pullup_en),
		.SLEEP_CLAMP(clamp), .EXT_INT_EN(int_en), .INPUT_CHANGE(change));
	ext_pad #(.PINS(8)) ext_pad_inst (.clk(clk), .pad_out(pad_out), .pad_oe(pad_oe),
		.pullup_en(pullup_en), .drive_en(drv_en), .drive_val(drv_val), .pad_in(pad_in));

	// ==========================================================
	// Clock at 40 MHz
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	// ==========================================================
	// Tasks
	// Verdict and end of run
	task automatic end_of_test();
		$display("Comparisons %0d, mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// Compare one value
	task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
		n_tests++;
		if (got !== exp) begin
			err_total++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// One APB transfer; held until pready is seen high at an edge
	task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		int i;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		for (i = 0; i < 20; i++) begin
			@(posedge clk);
			if (pready === 1'b1) break;
		end
		if (i == 20) begin
			err_total++;
			end_of_test();
		end else begin
			rd = prdata;
			er = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
		end
	endtask

	// Read and compare data and error flag
	task automatic rchk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e, input logic ee);
		apb(1'b0, a, '0);
		chk(rd, e);
		chk({31'h0, er}, {31'h0, ee});
	endtask

	// Let the edge's updates land, then look
	task automatic tick();
		@(posedge clk);
		#1;
	endtask

	// ==========================================================
	// Main sequence
	initial begin
		err_total = 0;
		n_tests = 0;
		rst = 1'b1;
		{psel, penable, pwrite, clamp} = '0;
		paddr = '0;
		pwdata = '0;
		drv_en = 8'hff;
		drv_val = 8'h5a;
		int_en = 8'h00;
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		// Reset values and an unmapped offset
		rchk(OFS_DIRECTION, 32'h0, 1'b0);
		rchk(OFS_OUTPUT, 32'h0, 1'b0);
		rchk(OFS_SPECIAL, 32'h0, 1'b0);
		rchk(12'h010, 32'h0, 1'b1);                      // Unmapped offset refused
		apb(1'b1, 12'h010, 32'hff);                      // Unmapped write refused
		chk({31'h0, er}, 32'h1);                         // Unmapped write flagged
		rchk(OFS_DIRECTION, 32'h0, 1'b0);
		rchk(OFS_PIN_STATE, 32'h5a, 1'b0);
		// Tri-state to output through the pull-up state
		apb(1'b1, OFS_OUTPUT, 32'hf0);
		tick();
		chk(pullup_en, 8'hf0);
		@(posedge clk);
		drv_en <= 8'hc3;
		apb(1'b1, OFS_DIRECTION, 32'h3c);
		tick();
		chk(pad_oe, 8'h3c);
		chk(pad_out, 8'hf0);
		chk(pullup_en, 8'hc0);
		tick();
		rchk(OFS_PIN_STATE, 32'h72, 1'b0);
		apb(1'b1, OFS_PIN_STATE, 32'hff);
		rchk(OFS_DIRECTION, 32'h3c, 1'b0);
		// Global pull-up disable
		apb(1'b1, OFS_SPECIAL, 32'h4);
		tick();
		chk(pullup_en, 8'h00);
		rchk(OFS_SPECIAL, 32'h4, 1'b0);
		// Sleep clamp with one interrupt pin bypassed
		clamp <= 1'b1;
		int_en <= 8'h02;
		rchk(OFS_PIN_STATE, 32'h02, 1'b0);
		clamp <= 1'b0;
		tick();
		chk(change, 8'h00);                              // Clamp release in pin state, event not yet out
		tick();
		chk(change, 8'h70);
		// Pad change on an edge: state at next edge, event one later
		@(posedge clk);
		drv_val <= 8'h5b;
		tick();
		chk(change, 8'h00);
		tick();
		chk(change, 8'h01);
		tick();
		chk(change, 8'h00);                              // Event lasts one cycle
		// Pull-ups back, then a mid-run reset tri-states at once
		apb(1'b1, OFS_SPECIAL, 32'h0);
		tick();
		chk(pullup_en, 8'hc0);
		@(posedge clk);
		rst <= 1'b1;
		#1;
		chk(pad_oe, 8'h00);
		chk(pullup_en, 8'h00);
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		rchk(OFS_DIRECTION, 32'h0, 1'b0);
		rchk(OFS_OUTPUT, 32'h0, 1'b0);
		end_of_test();
	end
endmodule
`default_nettype wire
